// ### blc_asserts.sv
`timescale 1ns/1ps
module blc_asserts (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // link wires and enable pin
  input wire logic scl,
  input wire logic sda,
  input wire logic hostSdaOe,
  input wire logic devSdaOe,
  input wire logic devIntOe,
  input wire logic hardwareEnableResetPin
);
  logic       sclQ_ff, sdaQ_ff, rdMode_ff, first_ff, busy_ff;
  logic [3:0] cnt_ff;
  wire        sclRise = scl & ~sclQ_ff;
  wire        sclFall = ~scl & sclQ_ff;
  wire        startEv = scl & sclQ_ff & sdaQ_ff & ~sda;
  wire        stopEv  = scl & sclQ_ff & ~sdaQ_ff & sda;
  wire        ackRise = sclRise & (cnt_ff == 4'h8);
  wire        wrAck   = ackRise & (first_ff | ~rdMode_ff);

  // previous wire levels
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sclQ_ff <= 1'b1;
      sdaQ_ff <= 1'b1;
    end else begin
      sclQ_ff <= scl;
      sdaQ_ff <= sda;
    end
  end

  // bit count, direction and bus occupancy
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_ff <= 4'h0;
      busy_ff <= 1'b0;
      first_ff <= 1'b1;
      rdMode_ff <= 1'b0;
    end else if (startEv) begin
      cnt_ff <= 4'h0;
      busy_ff <= 1'b1;
      first_ff <= 1'b1;
      rdMode_ff <= 1'b0;
    end else begin
      if (stopEv)
        busy_ff <= 1'b0;
      if (sclRise)
        cnt_ff <= (cnt_ff == 4'h9) ? 4'h1 : cnt_ff + 4'h1;
      if (sclRise && first_ff && cnt_ff == 4'h7)
        rdMode_ff <= sda;
      if (ackRise)
        first_ff <= 1'b0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_dev_steady: assert property (scl && sclQ_ff |-> $stable(devSdaOe))
    else $error("device moved data while clock high");
  chk_start_host: assert property (startEv || stopEv |-> $changed(hostSdaOe))
    else $error("start or stop not made by host");
  chk_busy_dev: assert property (devSdaOe |-> busy_ff)
    else $error("device drives data while bus idle");
  chk_byte_count: assert property (stopEv |-> cnt_ff == 4'h1)
    else $error("stop inside a byte");
  chk_ack_write: assert property (wrAck |-> !sda && devSdaOe)
    else $error("received byte not acknowledged");
  chk_read_quiet: assert property (ackRise && rdMode_ff && !first_ff |-> !devSdaOe)
    else $error("device acknowledged its own read byte");
  chk_host_release: assert property (wrAck |-> !hostSdaOe)
    else $error("host holds data in acknowledge slot");
  chk_answer_lag: assert property ($rose(devSdaOe) |-> $past(sclFall, 3) || $past(sclFall, 4) || $past(sclFall, 5))
    else $error("device took data off clock low phase");
  chk_enable_off: assert property (!hardwareEnableResetPin [*5] |-> !devSdaOe && !devIntOe)
    else $error("outputs active while enable low");

  cov_restart: cover property (startEv && busy_ff);
  cov_read: cover property (ackRise && rdMode_ff && !first_ff);
  cov_alert: cover property ($rose(devIntOe));
endmodule

// ### blc_host.sv
`timescale 1ns/1ps
module blc_host #(
  parameter int QTR_CYC = blc_pkg::HOST_QTR_CYC
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // serial link
  blc_if.host             bus,
  // command port
  input  wire logic       cmdValid,
  output logic            cmdReady,
  input  wire logic       cmdRead,
  input  wire logic [7:0] cmdReg,
  input  wire logic [7:0] cmdData,
  // results
  output logic            doneStb,
  output logic      [7:0] rdData,
  output logic            nackSeen,
  output logic            alert
);
  import blc_pkg::*;

  logic [1:0]   syncLvl;
  blc_host_st_e st_ff;
  logic [15:0]  qCnt_ff;
  logic         tick;
  logic [1:0]   phase_ff;
  logic [3:0]   bitCnt_ff;
  logic [2:0]   idx_ff;
  logic         rd_ff;
  logic [7:0]   reg_ff;
  logic [7:0]   data_ff;
  logic [7:0]   rxSh_ff;
  logic         scl_ff;
  logic         oe_ff;
  logic [7:0]   curByte;
  logic         isRx;

  blc_sync #(.WIDTH(2)) u_sync (
    .clock (clock),
    .rst   (rst),
    .async ({bus.sda, bus.intLine}),
    .level (syncLvl),
    .rise  (),
    .fall  ()
  );

  assign bus.scl        = scl_ff;
  assign bus.hostSdaOut = 1'b0;
  assign bus.hostSdaOe  = oe_ff;
  assign alert          = ~syncLvl[0];
  assign cmdReady       = (st_ff == HS_IDLE);
  assign tick           = (int'(qCnt_ff) == QTR_CYC - 1);
  assign isRx           = rd_ff && idx_ff == 3'h3;

  always_comb begin
    unique case (idx_ff)
      3'h0: curByte = {DEV_ADDR, 1'b0};
      3'h1: curByte = reg_ff;
      3'h2: curByte = rd_ff ? {DEV_ADDR, 1'b1} : data_ff;
      default: curByte = 8'hFF;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      qCnt_ff <= 16'h0000;
    end else if (st_ff == HS_IDLE || tick) begin
      qCnt_ff <= 16'h0000;
    end else begin
      qCnt_ff <= qCnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_ff     <= HS_IDLE;
      phase_ff  <= 2'h0;
      bitCnt_ff <= 4'h0;
      idx_ff    <= 3'h0;
      rd_ff     <= 1'b0;
      reg_ff    <= 8'h00;
      data_ff   <= 8'h00;
      rxSh_ff   <= 8'h00;
      scl_ff    <= 1'b1;
      oe_ff     <= 1'b0;
      doneStb   <= 1'b0;
      rdData    <= 8'h00;
      nackSeen  <= 1'b0;
    end else begin
      doneStb <= 1'b0;
      if (st_ff == HS_IDLE) begin
        if (cmdValid) begin
          st_ff    <= HS_START;
          phase_ff <= 2'h0;
          idx_ff   <= 3'h0;
          rd_ff    <= cmdRead;
          reg_ff   <= cmdReg;
          data_ff  <= cmdData;
          nackSeen <= 1'b0;
        end
      end else if (tick) begin
        phase_ff <= phase_ff + 2'h1;
        unique case (st_ff)
          HS_START: begin
            unique case (phase_ff)
              2'h0: oe_ff <= 1'b0;
              2'h1: scl_ff <= 1'b1;
              2'h2: oe_ff <= 1'b1;
              2'h3: begin
                scl_ff    <= 1'b0;
                st_ff     <= HS_BYTE;
                bitCnt_ff <= 4'h0;
              end
            endcase
          end
          HS_BYTE: begin
            unique case (phase_ff)
              // drive while clock low, release for ack
              2'h0: oe_ff <= (bitCnt_ff < ACK_SLOT) && !isRx && !curByte[3'h7 - bitCnt_ff[2:0]];
              2'h1: scl_ff <= 1'b1;
              2'h2: begin
                if (bitCnt_ff < ACK_SLOT) begin
                  rxSh_ff <= {rxSh_ff[6:0], syncLvl[1]};
                end
              end
              2'h3: begin
                scl_ff <= 1'b0;
                if (bitCnt_ff != ACK_SLOT) begin
                  bitCnt_ff <= bitCnt_ff + 4'h1;
                end else if (isRx) begin
                  rdData <= rxSh_ff;
                  st_ff  <= HS_STOP;
                end else if (syncLvl[1]) begin
                  nackSeen <= 1'b1;
                  st_ff    <= HS_STOP;
                end else begin
                  idx_ff    <= idx_ff + 3'h1;
                  bitCnt_ff <= 4'h0;
                  if (rd_ff && idx_ff == 3'h1) begin
                    st_ff <= HS_START;
                  end else if (!rd_ff && idx_ff == 3'h2) begin
                    st_ff <= HS_STOP;
                  end
                end
              end
            endcase
          end
          HS_STOP: begin
            unique case (phase_ff)
              2'h0: oe_ff <= 1'b1;
              2'h1: scl_ff <= 1'b1;
              2'h2: oe_ff <= 1'b0;
              2'h3: begin
                st_ff   <= HS_IDLE;
                doneStb <= 1'b1;
              end
            endcase
          end
          default: st_ff <= HS_IDLE;
        endcase
      end
    end
  end
endmodule

// ### blc_if.sv
`timescale 1ns/1ps
interface blc_if;
  logic scl;
  logic hostSdaOut;
  logic hostSdaOe;
  logic devSdaOut;
  logic devSdaOe;
  logic devIntOut;
  logic devIntOe;
  logic sda;
  logic intLine;

  // open-drain wires with pull-ups
  assign sda = ~((hostSdaOe & ~hostSdaOut) | (devSdaOe & ~devSdaOut));
  assign intLine = ~(devIntOe & ~devIntOut);

  modport host (output scl, output hostSdaOut, output hostSdaOe, input sda, input intLine);
  modport dev (input scl, input sda, output devSdaOut, output devSdaOe, output devIntOut, output devIntOe);
endinterface

// ### blc_pkg.sv
package blc_pkg;
  // system clock
  localparam int CLK_NS = 10;

  // bus address and byte layout
  localparam logic [6:0] DEV_ADDR = 7'h38;
  localparam int         BYTE_BITS = 8;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;

  // register map
  localparam int         NREG = 15;
  localparam logic [7:0] REG_ADDR [NREG] = '{8'h10, 8'h20, 8'h30, 8'h60, 8'h61, 8'h62, 8'h63,
                                             8'h70, 8'h71, 8'h72, 8'h73, 8'h74, 8'hA0, 8'hB0, 8'hC0};
  localparam logic [7:0] REG_RST [NREG]  = '{8'h00, 8'h00, 8'h00, 8'h33, 8'h66, 8'h99, 8'hCC,
                                             8'h99, 8'hB6, 8'hCC, 8'hE6, 8'hFF, 8'h80, 8'hC0, 8'hF8};
  localparam int         R_DIODE = 0;
  localparam int         R_CFG = 1;
  localparam int         R_OPT = 2;
  localparam int         R_TRIP = 3;
  localparam int         N_TRIP = 4;
  localparam int         R_ZBRT = 7;
  localparam int         R_GRPA = 12;
  localparam int         R_GRPB = 13;
  localparam int         R_GRPC = 14;
  localparam logic [7:0] ZONE_ADDR = 8'h40;
  localparam logic [7:0] ZONE_RB_BASE = 8'hF0;
  localparam logic [7:0] GRPA_FIXED = 8'h80;

  // field positions
  localparam int CFG_PWM_EN = 0;
  localparam int CFG_PWM_POL = 1;
  localparam int CFG_ALS_ENA = 4;
  localparam int CFG_ALS_EN = 6;
  localparam int CFG_ALSF = 7;
  localparam int OPT_GT_LSB = 6;

  // gain transition filter times, least value of each range
  localparam int GT_NS0 = 3_000_000;
  localparam int GT_NS1 = 800_000;
  localparam int GT_NS2 = 20_000;
  localparam int GT_NS3 = 1_000;
  localparam int GT_CYC0 = (GT_NS0 + CLK_NS - 1) / CLK_NS;
  localparam int GT_CYC1 = (GT_NS1 + CLK_NS - 1) / CLK_NS;
  localparam int GT_CYC2 = (GT_NS2 + CLK_NS - 1) / CLK_NS;
  localparam int GT_CYC3 = (GT_NS3 + CLK_NS - 1) / CLK_NS;

  // host serial clock, a quarter of its period in cycles
  localparam int HOST_QTR_CYC = 64;

  typedef enum logic [5:0] {
    DS_IDLE  = 6'b00_0001,
    DS_ADDR  = 6'b00_0010,
    DS_REG   = 6'b00_0100,
    DS_WDATA = 6'b00_1000,
    DS_READ  = 6'b01_0000,
    DS_SKIP  = 6'b10_0000
  } blc_dev_st_e;

  typedef enum logic [3:0] {
    HS_IDLE  = 4'b0001,
    HS_START = 4'b0010,
    HS_BYTE  = 4'b0100,
    HS_STOP  = 4'b1000
  } blc_host_st_e;
endpackage

// ### blc_sync.sv
`timescale 1ns/1ps
module blc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // asynchronous inputs and their synchronised forms
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] prev_ff;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      level   <= '0;
      prev_ff <= '0;
    end else begin
      meta_ff <= async;
      level   <= meta_ff;
      prev_ff <= level;
    end
  end

  assign rise = level & ~prev_ff;
  assign fall = ~level & prev_ff;
endmodule

// ### blc_target.sv
`timescale 1ns/1ps
module blc_target #(
  parameter int GT_SLOW_CYC = blc_pkg::GT_CYC0,
  parameter int GT_MID_CYC  = blc_pkg::GT_CYC1,
  parameter bit DUAL_SENSOR = 1'b1
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // serial link
  blc_if.dev              bus,
  // pins from the board
  input  wire logic       hardwareEnableResetPin,
  input  wire logic       contentBrightnessControlPin,
  input  wire logic [7:0] sinkLowPin,
  input  wire logic [7:0] ambientLightSensingLevel,
  // controls to the analog side
  output logic      [7:0] sinkOn,
  output logic            pumpGain32,
  output logic      [6:0] groupACode,
  output logic      [2:0] groupBCode,
  output logic      [2:0] groupCCode,
  output logic      [2:0] alsZone
);
  import blc_pkg::*;

  localparam logic [3:0] START_CNT = 4'hF;

  logic [19:0]  syncLvl;
  logic [19:0]  syncRise;
  logic [19:0]  syncFall;
  logic         sclL;
  logic         sdaL;
  logic         sclRise;
  logic         sclFall;
  logic         sdaRise;
  logic         sdaFall;
  logic         hardware_enable_reset_pin;
  logic         pwmL;
  logic [7:0]   lowL;
  logic [7:0]   lvlL;
  logic         clr;
  blc_dev_st_e  st_ff;
  logic [3:0]   bitCnt_ff;
  logic [7:0]   rxSh_ff;
  logic [7:0]   txSh_ff;
  logic [7:0]   ptr_ff;
  logic         rw_ff;
  logic         hostNack_ff;
  logic         sdaOe_ff;
  logic         wrStb_ff;
  logic         rdHit_ff;
  logic [7:0]   regs_ff [NREG];
  logic [7:0]   rdData;
  logic [2:0]   zoneNow;
  logic [2:0]   zone_ff;
  logic         intPend_ff;
  logic         headLow;
  logic [1:0]   gainTransitionFilterField;
  int           gtLim;
  logic [19:0]  gtCnt_ff;
  logic         gain32_ff;
  logic         pwmGate;
  logic         alsA;

  blc_sync #(.WIDTH(20)) u_sync (
    .clock (clock),
    .rst   (rst),
    .async ({bus.scl, bus.sda, hardwareEnableResetPin, contentBrightnessControlPin,
             sinkLowPin, ambientLightSensingLevel}),
    .level (syncLvl),
    .rise  (syncRise),
    .fall  (syncFall)
  );

  assign sclL = syncLvl[19];
  assign sdaL = syncLvl[18];
  assign hardware_enable_reset_pin = syncLvl[17];
  assign pwmL = syncLvl[16];
  assign lowL = syncLvl[15:8];
  assign lvlL = syncLvl[7:0];
  assign sclRise = syncRise[19];
  assign sclFall = syncFall[19];
  assign sdaRise = syncRise[18];
  assign sdaFall = syncFall[18];
  assign clr = ~hardware_enable_reset_pin;

  assign bus.devSdaOut = 1'b0;
  assign bus.devSdaOe  = sdaOe_ff;
  assign bus.devIntOut = 1'b0;
  assign bus.devIntOe  = intPend_ff;

  // serial protocol engine
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_ff       <= DS_IDLE;
      bitCnt_ff   <= 4'h0;
      rxSh_ff     <= 8'h00;
      txSh_ff     <= 8'h00;
      ptr_ff      <= 8'h00;
      rw_ff       <= 1'b0;
      hostNack_ff <= 1'b0;
      sdaOe_ff    <= 1'b0;
      wrStb_ff    <= 1'b0;
      rdHit_ff    <= 1'b0;
    end else begin
      wrStb_ff <= 1'b0;
      rdHit_ff <= 1'b0;
      if (clr || (sdaRise && sclL)) begin
        st_ff     <= DS_IDLE;
        bitCnt_ff <= 4'h0;
        sdaOe_ff  <= 1'b0;
      end else if (sdaFall && sclL) begin
        st_ff     <= DS_ADDR;
        // clock fall after start is no bit edge
        bitCnt_ff <= START_CNT;
        sdaOe_ff  <= 1'b0;
      end else if (st_ff != DS_IDLE && st_ff != DS_SKIP) begin
        if (sclRise) begin
          if (bitCnt_ff < ACK_SLOT) begin
            rxSh_ff <= {rxSh_ff[6:0], sdaL};
          end else if (st_ff == DS_READ) begin
            hostNack_ff <= sdaL;
          end
        end
        if (sclFall) begin
          if (bitCnt_ff == LAST_BIT) begin
            bitCnt_ff <= ACK_SLOT;
            unique case (st_ff)
              DS_ADDR: begin
                if (rxSh_ff[7:1] == DEV_ADDR) begin
                  sdaOe_ff <= 1'b1;
                  rw_ff    <= rxSh_ff[0];
                  rdHit_ff <= rxSh_ff[0];
                end else begin
                  st_ff <= DS_SKIP;
                end
              end
              DS_REG: begin
                sdaOe_ff <= 1'b1;
                ptr_ff   <= rxSh_ff;
              end
              DS_WDATA: begin
                sdaOe_ff <= 1'b1;
                wrStb_ff <= 1'b1;
              end
              DS_READ: begin
                sdaOe_ff <= 1'b0;
              end
            endcase
          end else if (bitCnt_ff == ACK_SLOT) begin
            bitCnt_ff <= 4'h0;
            sdaOe_ff  <= 1'b0;
            unique case (st_ff)
              DS_ADDR: begin
                st_ff <= rw_ff ? DS_READ : DS_REG;
                if (rw_ff) begin
                  txSh_ff  <= rdData;
                  sdaOe_ff <= ~rdData[7];
                end
              end
              DS_REG: begin
                st_ff <= DS_WDATA;
              end
              DS_WDATA: begin
                st_ff <= DS_WDATA;
              end
              DS_READ: begin
                if (hostNack_ff) begin
                  st_ff <= DS_SKIP;
                end else begin
                  txSh_ff  <= rdData;
                  sdaOe_ff <= ~rdData[7];
                end
              end
            endcase
          end else begin
            bitCnt_ff <= bitCnt_ff + 4'h1;
            if (st_ff == DS_READ) begin
              txSh_ff  <= {txSh_ff[6:0], 1'b0};
              sdaOe_ff <= ~txSh_ff[6];
            end
          end
        end
      end
    end
  end

  // register file
  for (genvar i = 0; i < NREG; i++) begin : g_reg
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        regs_ff[i] <= REG_RST[i];
      end else if (clr) begin
        regs_ff[i] <= REG_RST[i];
      end else if (wrStb_ff && ptr_ff == REG_ADDR[i]) begin
        regs_ff[i] <= rxSh_ff;
      end
    end
  end

  // read data for the selected register
  always_comb begin
    rdData = 8'h00;
    if (ptr_ff == ZONE_ADDR) begin
      rdData = ZONE_RB_BASE | {5'h00, zone_ff};
    end
    for (int i = 0; i < NREG; i++) begin
      if (ptr_ff == REG_ADDR[i]) begin
        rdData = (i == R_GRPA) ? (regs_ff[i] | GRPA_FIXED) : regs_ff[i];
      end
    end
  end

  always_comb begin
    zoneNow = 3'h0;
    for (int i = 0; i < N_TRIP; i++) begin
      if (lvlL > regs_ff[R_TRIP + i]) begin
        zoneNow = zoneNow + 3'h1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      zone_ff    <= 3'h0;
      intPend_ff <= 1'b0;
    end else if (clr) begin
      zone_ff    <= 3'h0;
      intPend_ff <= 1'b0;
    end else if (regs_ff[R_CFG][CFG_ALS_EN]) begin
      zone_ff <= zoneNow;
      if (zoneNow != zone_ff && regs_ff[R_CFG][CFG_ALSF]) begin
        intPend_ff <= 1'b1;
      end else if (rdHit_ff) begin
        intPend_ff <= 1'b0;
      end
    end else if (rdHit_ff) begin
      intPend_ff <= 1'b0;
    end
  end

  assign headLow = |(lowL & regs_ff[R_DIODE]);
  assign gainTransitionFilterField = regs_ff[R_OPT][OPT_GT_LSB +: 2];

  always_comb begin
    unique case (gainTransitionFilterField)
      2'h0: gtLim = GT_SLOW_CYC;
      2'h1: gtLim = GT_MID_CYC;
      2'h2: gtLim = GT_CYC2;
      2'h3: gtLim = DUAL_SENSOR ? GT_CYC3 : GT_CYC2;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gtCnt_ff <= 20'h0_0000;
    end else if (clr || wrStb_ff || !headLow || gain32_ff) begin
      gtCnt_ff <= 20'h0_0000;
    end else begin
      gtCnt_ff <= gtCnt_ff + 20'h0_0001;
    end
  end

  // gain select, switch wins over write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gain32_ff <= 1'b0;
    end else if (clr) begin
      gain32_ff <= 1'b0;
    end else if (headLow && !gain32_ff && int'(gtCnt_ff) >= gtLim - 1) begin
      gain32_ff <= 1'b1;
    end else if (wrStb_ff) begin
      gain32_ff <= 1'b0;
    end
  end

  assign pwmGate = ~regs_ff[R_CFG][CFG_PWM_EN] | (pwmL ^ regs_ff[R_CFG][CFG_PWM_POL]);
  assign alsA = regs_ff[R_CFG][CFG_ALS_EN] & regs_ff[R_CFG][CFG_ALS_ENA];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sinkOn     <= 8'h00;
      pumpGain32 <= 1'b0;
      groupACode <= 7'h00;
      groupBCode <= 3'h0;
      groupCCode <= 3'h0;
      alsZone    <= 3'h0;
    end else if (clr) begin
      sinkOn     <= 8'h00;
      pumpGain32 <= 1'b0;
      groupACode <= 7'h00;
      groupBCode <= 3'h0;
      groupCCode <= 3'h0;
      alsZone    <= 3'h0;
    end else begin
      sinkOn     <= regs_ff[R_DIODE] & {8{pwmGate}};
      pumpGain32 <= gain32_ff;
      groupACode <= alsA ? regs_ff[R_ZBRT + int'(zone_ff)][6:0] : regs_ff[R_GRPA][6:0];
      groupBCode <= regs_ff[R_GRPB][2:0];
      groupCCode <= regs_ff[R_GRPC][2:0];
      alsZone    <= zone_ff;
    end
  end
endmodule

// ### testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
  import blc_pkg::*;
  logic       clock, rst, cmdValid, cmdReady, cmdRead, doneStb, nackSeen, alert, pumpGain32;
  logic       hardwareEnableResetPin, contentBrightnessControlPin;
  logic [7:0] cmdReg, cmdData, rdData, sinkLowPin, ambientLightSensingLevel, sinkOn;
  logic [6:0] groupACode;
  logic [2:0] groupBCode, groupCCode, alsZone, z;
  logic [7:0] dv [4];
  logic [7:0] pick [4] = '{8'h10, 8'hA0, 8'hB0, 8'hC0};
  int         n_errors = 0, samples_checked = 0, lim;
  localparam int PWM_HOLD = 15_000 / CLK_NS;

  blc_if link ();
  blc_host #(.QTR_CYC(16)) u_blc_host (.clock, .rst, .bus(link.host), .cmdValid, .cmdReady, .cmdRead, .cmdReg,
    .cmdData, .doneStb, .rdData, .nackSeen, .alert);
  blc_target #(.GT_SLOW_CYC(40), .GT_MID_CYC(20)) u_blc_target (.clock, .rst, .bus(link.dev), .hardwareEnableResetPin,
    .contentBrightnessControlPin, .sinkLowPin, .ambientLightSensingLevel, .sinkOn, .pumpGain32, .groupACode, .groupBCode,
    .groupCCode, .alsZone);
  blc_asserts u_blc_asserts (.clock, .rst, .scl(link.scl), .sda(link.sda), .hostSdaOe(link.hostSdaOe),
    .devSdaOe(link.devSdaOe), .devIntOe(link.devIntOe), .hardwareEnableResetPin);

  function automatic int gt(input int g);
    return g == 0 ? 40 : g == 1 ? 20 : g == 2 ? GT_CYC2 : GT_CYC3;
  endfunction

  task automatic xfer(input logic r, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(negedge clock);
    `CHK("ready", 1'b1, cmdReady)
    cmdValid = 1'b1;
    cmdRead = r;
    cmdReg = a;
    cmdData = d;
    @(negedge clock);
    cmdValid = 1'b0;
    k = 0;
    while (doneStb !== 1'b1 && k < 9000) begin
      @(negedge clock);
      k++;
    end
    `CHK("done", 1'b1, doneStb)
    `CHK("nack", 1'b0, nackSeen)
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b1, a, 8'h00);
    `CHK("rdData", e, rdData)
  endtask

  task automatic results();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    repeat (90000) @(posedge clock);
    n_errors++;
    results();
  end

  initial begin
    {cmdValid, cmdRead, cmdReg, cmdData, contentBrightnessControlPin, sinkLowPin, ambientLightSensingLevel} = '0;
    rst = 1'b1;
    hardwareEnableResetPin = 1'b1;
    void'($urandom(37212));
    repeat (20) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    for (int i = 0; i < 3; i++) begin
      lim = $urandom % NREG;
      rdc(REG_ADDR[lim], REG_RST[lim]);
    end
    rdc(ZONE_ADDR, ZONE_RB_BASE);
    $display("end defaults");
    for (int i = 0; i < 4; i++) begin
      dv[i] = 8'($urandom);
      xfer(1'b0, pick[i], dv[i]);
    end
    `CHK("sinkOn", dv[0], sinkOn)
    `CHK("grpA", dv[1][6:0], groupACode)
    `CHK("grpB", dv[2][2:0], groupBCode)
    `CHK("grpC", dv[3][2:0], groupCCode)
    rdc(8'hA0, dv[1] | 8'h80);
    xfer(1'b0, 8'h50, 8'($urandom));
    rdc(8'h50, 8'h00);
    `CHK("sinkOn kept", dv[0], sinkOn)
    $display("end writes");
    for (int c = 0; c < 4; c++) begin
      xfer(1'b0, 8'h20, 8'(c));
      for (int p = 0; p < 2; p++) begin
        contentBrightnessControlPin = p[0];
        repeat (PWM_HOLD) @(negedge clock);
        `CHK("pwm", (c[0] == 1'b0 || p[0] == !c[1]) ? dv[0] : 8'h00, sinkOn)
      end
    end
    $display("end pwm");
    xfer(1'b0, 8'h20, 8'h00);
    xfer(1'b0, 8'h10, 8'h0F);
    for (int g = 0; g < 4; g++) begin
      lim = gt(g);
      xfer(1'b0, 8'h30, 8'(g << 6));
      sinkLowPin = 8'hF0;
      repeat (lim + 20) @(negedge clock);
      `CHK("gain off", 1'b0, pumpGain32)
      sinkLowPin = 8'h01;
      repeat (lim - 3) @(negedge clock);
      `CHK("gain early", 1'b0, pumpGain32)
      repeat (16) @(negedge clock);
      `CHK("gain up", 1'b1, pumpGain32)
      sinkLowPin = 8'h00;
      repeat (20) @(negedge clock);
      `CHK("gain held", 1'b1, pumpGain32)
      xfer(1'b0, 8'h10, 8'h0F);
      `CHK("gain back", 1'b0, pumpGain32)
    end
    $display("end gain");
    hardwareEnableResetPin = 1'b0;
    repeat (10) @(negedge clock);
    `CHK("sinkOn off", 8'h00, sinkOn)
    `CHK("grpA off", 7'h00, groupACode)
    hardwareEnableResetPin = 1'b1;
    repeat (6) @(negedge clock);
    rdc(8'h10, 8'h00);
    $display("end enable");
    xfer(1'b0, 8'h20, 8'hD0);
    ambientLightSensingLevel = 8'h34 + 8'($urandom % 200);
    z = 3'h0;
    for (int i = 0; i < N_TRIP; i++)
      if (REG_RST[R_TRIP + i] < ambientLightSensingLevel)
        z++;
    repeat (20) @(negedge clock);
    `CHK("zone", z, alsZone)
    `CHK("zone brt", REG_RST[R_ZBRT + z][6:0], groupACode)
    `CHK("int", 1'b0, link.intLine)
    `CHK("alert", 1'b1, alert)
    rdc(ZONE_ADDR, ZONE_RB_BASE | {5'h00, z});
    `CHK("int clr", 1'b1, link.intLine)
    $display("end interrupt");
    results();
  end
endmodule
